// >>> design/wide_simd_sub_xor_shift_store.sv
`default_nettype none
module wide_simd_sub_xor_shift_store (
	input  wire logic                             REF_CLK_I,
	input  wire logic                             RESET_I,
	input  wire logic                             ISSUE_VALID_I,
	input  wire logic [simd_pkg::INSTR_W-1:0]     INSTR_I,
	input  wire logic [simd_pkg::DATA_W-1:0]      SRC_FIRST_I,
	input  wire logic [simd_pkg::DATA_W-1:0]      SRC_SECOND_I,
	input  wire logic [simd_pkg::SA_W-1:0]        SHIFT_AMOUNT_REG_I,
	output logic      [simd_pkg::DATA_W-1:0]      RESULT_O,
	output logic      [simd_pkg::REG_IDX_W-1:0]   DEST_REG_O,
	output logic                                  RESULT_VALID_O,
	output logic                                  STORE_REQ_O,
	output logic      [simd_pkg::ADDR_W-1:0]      STORE_ADDR_O,
	output logic      [simd_pkg::DATA_W-1:0]      STORE_DATA_O,
	output logic                                  RSVD_INSTR_EXC_O
);
	import simd_pkg::*;

	function automatic op_t decode_op(input logic [INSTR_W-1:0] ins);
		logic [5:0] opc;
		logic [5:0] fn;
		logic [4:0] sub;
		op_t op;
		opc = ins[OPC_HI:OPC_LO];
		fn = ins[FN_HI:FN_LO];
		sub = ins[SUB_HI:SUB_LO];
		op = OP_NONE;
		if (RSVD_PRIMARY[opc]) begin
			op = OP_RESERVED;
		end else if (opc == OPC_STORE_QUADWORD) begin
			op = OP_STORE_QW;
		end else if (opc == OPC_MULTIMEDIA) begin
			if (fn == FN_SUBCLASS_0 && RSVD_SUBCLASS_0[sub]) begin
				op = OP_RESERVED;
			end else if (fn == FN_SUBCLASS_1 && RSVD_SUBCLASS_1[sub]) begin
				op = OP_RESERVED;
			end else if (fn == FN_SUBCLASS_2 && RSVD_SUBCLASS_2[sub]) begin
				op = OP_RESERVED;
			end else if (fn == FN_SUBCLASS_0 && sub == SUB_WRAP_WORD) begin
				op = OP_WRAP_WORD;
			end else if (fn == FN_SUBCLASS_1 && sub == SUB_SAT_WORD) begin
				op = OP_SAT_WORD;
			end else if (fn == FN_SUBCLASS_1 && sub == SUB_FUNNEL_RIGHT) begin
				op = OP_FUNNEL_RIGHT;
			end else if (fn == FN_SUBCLASS_2 && sub == SUB_WIDE_XOR) begin
				op = OP_WIDE_XOR;
			end
		end
		return op;
	endfunction : decode_op

	op_t                 issue_op;
	logic [DATA_W-1:0]   sat_res;
	logic [DATA_W-1:0]   wrap_res;
	logic [DATA_W-1:0]   fsr_res;
	logic [2*DATA_W-1:0] funnel_cat;
	logic [ADDR_W-1:0]   ea_full;

	logic [DATA_W-1:0]    result_reg, result_next;
	logic [REG_IDX_W-1:0] dest_reg, dest_next;
	logic                 valid_reg, valid_next;
	logic                 st_req_reg, st_req_next;
	logic [ADDR_W-1:0]    st_addr_reg, st_addr_next;
	logic [DATA_W-1:0]    st_data_reg, st_data_next;
	logic                 ri_reg, ri_next;

	assign issue_op = ISSUE_VALID_I ? decode_op(INSTR_I) : OP_NONE;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [LANE_W-1:0] a_lane;
			logic [LANE_W-1:0] b_lane;
			logic [LANE_W:0]   diff;
			assign a_lane = SRC_FIRST_I[g*LANE_W +: LANE_W];
			assign b_lane = SRC_SECOND_I[g*LANE_W +: LANE_W];
			assign diff = {1'b0, a_lane} - {1'b0, b_lane};
			assign sat_res[g*LANE_W +: LANE_W] =
				diff[LANE_W] ? SAT_FLOOR : diff[LANE_W-1:0];
			assign wrap_res[g*LANE_W +: LANE_W] = diff[LANE_W-1:0];
		end
	endgenerate

	// low three amount bits ignored, byte mux is cheaper
	assign funnel_cat = {SRC_FIRST_I, SRC_SECOND_I}
		>> {SHIFT_AMOUNT_REG_I[SA_W-1:BYTE_SHIFT], 3'h0};
	assign fsr_res = funnel_cat[DATA_W-1:0];

	assign ea_full = SRC_FIRST_I[ADDR_W-1:0]
		+ {{(ADDR_W-OFS_W){INSTR_I[OFS_W-1]}}, INSTR_I[OFS_W-1:0]};

	always_comb begin
		result_next = result_reg;
		dest_next = dest_reg;
		valid_next = 1'b0;
		st_req_next = 1'b0;
		st_addr_next = st_addr_reg;
		st_data_next = st_data_reg;
		ri_next = 1'b0;
		dest_next = INSTR_I[RD_HI:RD_LO];
		unique case (issue_op)
			OP_SAT_WORD: begin
				result_next = sat_res;
				valid_next = 1'b1;
			end
			OP_WRAP_WORD: begin
				result_next = wrap_res;
				valid_next = 1'b1;
			end
			OP_WIDE_XOR: begin
				result_next = SRC_FIRST_I ^ SRC_SECOND_I;
				valid_next = 1'b1;
			end
			OP_FUNNEL_RIGHT: begin
				result_next = fsr_res;
				valid_next = 1'b1;
			end
			// alignment forced, so no alignment fault exists
			OP_STORE_QW: begin
				st_req_next = 1'b1;
				st_addr_next = {ea_full[ADDR_W-1:ALIGN_BITS], 4'h0};
				st_data_next = SRC_SECOND_I;
			end
			OP_RESERVED: begin
				ri_next = 1'b1;
			end
			OP_NONE: begin
				dest_next = dest_reg;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			result_reg <= '0;
			dest_reg <= '0;
			valid_reg <= 1'b0;
			st_req_reg <= 1'b0;
			st_addr_reg <= '0;
			st_data_reg <= '0;
			ri_reg <= 1'b0;
		end else begin
			result_reg <= result_next;
			dest_reg <= dest_next;
			valid_reg <= valid_next;
			st_req_reg <= st_req_next;
			st_addr_reg <= st_addr_next;
			st_data_reg <= st_data_next;
			ri_reg <= ri_next;
		end
	end

	assign RESULT_O = result_reg;
	assign DEST_REG_O = dest_reg;
	assign RESULT_VALID_O = valid_reg;
	assign STORE_REQ_O = st_req_reg;
	assign STORE_ADDR_O = st_addr_reg;
	assign STORE_DATA_O = st_data_reg;
	assign RSVD_INSTR_EXC_O = ri_reg;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);

	logic is_sat, is_wrap, is_xor, is_fsr, is_sq, is_rsvd;
	assign is_sat = issue_op == OP_SAT_WORD;
	assign is_wrap = issue_op == OP_WRAP_WORD;
	assign is_xor = issue_op == OP_WIDE_XOR;
	assign is_fsr = issue_op == OP_FUNNEL_RIGHT;
	assign is_sq = issue_op == OP_STORE_QW;
	assign is_rsvd = issue_op == OP_RESERVED;

	a_sat_lane_clamp: assert property (
		is_sat && SRC_FIRST_I[127:96] < SRC_SECOND_I[127:96]
		|=> RESULT_VALID_O && RESULT_O[127:96] == 32'h0000_0000)
		else $error("saturating lane did not clamp");
	a_sat_no_trap: assert property (
		is_sat |=> RESULT_VALID_O && !RSVD_INSTR_EXC_O
		&& RESULT_O[31:0] == (
		$past(SRC_FIRST_I[31:0]) >= $past(SRC_SECOND_I[31:0])
		? $past(SRC_FIRST_I[31:0]) - $past(SRC_SECOND_I[31:0])
		: 32'h0))
		else $error("saturating subtract wrong or trapped");
	a_wrap_lane_low: assert property (
		is_wrap |=> RESULT_O[63:32]
		== 32'($past(SRC_FIRST_I[63:32]) - $past(SRC_SECOND_I[63:32])))
		else $error("wrapping lane mismatch");
	a_wrap_no_trap: assert property (
		is_wrap |=> RESULT_VALID_O && !RSVD_INSTR_EXC_O)
		else $error("wrapping subtract trapped");
	a_xor_full_width: assert property (
		is_xor |=> RESULT_VALID_O
		&& RESULT_O == ($past(SRC_FIRST_I) ^ $past(SRC_SECOND_I)))
		else $error("wide xor mismatch");
	a_fsr_zero_copy: assert property (
		is_fsr && SHIFT_AMOUNT_REG_I == 7'h00
		|=> RESULT_O == $past(SRC_SECOND_I))
		else $error("zero funnel shift not a copy");
	a_fsr_byte_step: assert property (
		is_fsr && SHIFT_AMOUNT_REG_I == 7'h08
		|=> RESULT_O == {$past(SRC_FIRST_I[7:0]), $past(SRC_SECOND_I[127:8])})
		else $error("byte funnel shift mismatch");
	a_sq_addr_form: assert property (
		is_sq |=> STORE_REQ_O && STORE_ADDR_O[3:0] == 4'h0
		&& STORE_ADDR_O[31:4] == $past(ea_full[31:4])
		&& STORE_DATA_O == $past(SRC_SECOND_I))
		else $error("store address or data wrong");
	a_sq_no_align: assert property (
		STORE_REQ_O |-> !RSVD_INSTR_EXC_O && !RESULT_VALID_O)
		else $error("store raised a fault");
	a_rsvd_sub_trap: assert property (
		ISSUE_VALID_I && INSTR_I[31:26] == 6'h1C && INSTR_I[5:0] == 6'h28
		&& INSTR_I[10:6] == 5'h1C |=> RSVD_INSTR_EXC_O && !RESULT_VALID_O)
		else $error("reserved sub-function not trapped");
	a_rsvd_prim_trap: assert property (
		ISSUE_VALID_I && INSTR_I[31:26] == 6'h30
		|=> RSVD_INSTR_EXC_O ##1 !RSVD_INSTR_EXC_O || $past(is_rsvd))
		else $error("reserved primary not trapped");
	a_class_decode: assert property (
		ISSUE_VALID_I && INSTR_I[31:26] == 6'h1C && INSTR_I[5:0] == 6'h09
		&& INSTR_I[10:6] == 5'h13 |-> is_xor)
		else $error("subtable decode wrong");
	a_sub_mapping: assert property (
		ISSUE_VALID_I && INSTR_I[31:26] == 6'h1C && INSTR_I[5:0] == 6'h08
		&& INSTR_I[10:6] == 5'h01 |-> is_wrap)
		else $error("subclass 0 subtract not decoded");
endmodule : wide_simd_sub_xor_shift_store
`default_nettype wire

// >>> include/simd_pkg.sv
`default_nettype none
package simd_pkg;
	localparam int DATA_W = 128;
	localparam int LANE_W = 32;
	localparam int LANES = 4;
	localparam int ADDR_W = 32;
	localparam int INSTR_W = 32;
	localparam int SA_W = 7;
	localparam int REG_IDX_W = 5;
	// instruction field positions
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int RT_HI = 20;
	localparam int RT_LO = 16;
	localparam int RD_HI = 15;
	localparam int RD_LO = 11;
	localparam int SUB_HI = 10;
	localparam int SUB_LO = 6;
	localparam int FN_HI = 5;
	localparam int FN_LO = 0;
	localparam int OFS_W = 16;
	localparam int ALIGN_BITS = 4;
	localparam int BYTE_SHIFT = 3;
	// primary opcodes
	localparam logic [5:0] OPC_MULTIMEDIA = 6'h1C;
	localparam logic [5:0] OPC_STORE_QUADWORD = 6'h1F;
	// multimedia function selectors (bits 5..0)
	localparam logic [5:0] FN_SUBCLASS_0 = 6'h08;
	localparam logic [5:0] FN_SUBCLASS_1 = 6'h28;
	localparam logic [5:0] FN_SUBCLASS_2 = 6'h09;
	// sub-function codes (bits 10..6)
	localparam logic [4:0] SUB_WRAP_WORD = 5'h01;
	localparam logic [4:0] SUB_SAT_WORD = 5'h11;
	localparam logic [4:0] SUB_FUNNEL_RIGHT = 5'h1B;
	localparam logic [4:0] SUB_WIDE_XOR = 5'h13;
	// one bit per sub-function value: set means reserved
	localparam logic [31:0] RSVD_SUBCLASS_0 = 32'h3000_F800;
	localparam logic [31:0] RSVD_SUBCLASS_1 = 32'hF088_FB01;
	localparam logic [31:0] RSVD_SUBCLASS_2 = 32'h03C0_08E6;
	// one bit per primary opcode: unsupported slots
	localparam logic [63:0] RSVD_PRIMARY = 64'h1515_0000_0000_0000;
	localparam logic [LANE_W-1:0] SAT_FLOOR = 32'h0000_0000;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SAT_WORD,
		OP_WRAP_WORD,
		OP_WIDE_XOR,
		OP_FUNNEL_RIGHT,
		OP_STORE_QW,
		OP_RESERVED
	} op_t;
endpackage : simd_pkg
`default_nettype wire

// >>> tb/store_sink.sv
`default_nettype none
module store_sink (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        req_i,
	input  wire logic [simd_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [simd_pkg::DATA_W-1:0] data_i,
	output logic      [simd_pkg::ADDR_W-1:0] addr_o,
	output logic      [simd_pkg::DATA_W-1:0] data_o,
	output logic      [7:0]                  count_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import simd_pkg::*;
	// no translation fault
	// sink always accepts; faults would come from here, never from the slice
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_o <= '0;
			data_o <= '0;
			count_o <= 8'h00;
		end else if (req_i) begin
			addr_o <= addr_i;
			data_o <= data_i;
			count_o <= count_o + 8'h01;
		end
	end
endmodule : store_sink
`default_nettype wire

// >>> tb/wide_simd_sub_xor_shift_store_bench.sv
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module wide_simd_sub_xor_shift_store_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import simd_pkg::*;
	typedef struct {
		logic [INSTR_W-1:0] ins;
		logic [DATA_W-1:0]  a;
		logic [DATA_W-1:0]  b;
		logic [SA_W-1:0]    sa;
		int                 kind;
	} row_t;
	localparam logic [DATA_W-1:0] A = 128'h5_0000_0010_FFFF_FFFF_0000_0000;
	localparam logic [DATA_W-1:0] B = 128'h6_0000_0010_0000_0001_0000_0001;
	localparam logic [DATA_W-1:0] C = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_FF00;
	localparam logic [DATA_W-1:0] BASE = 128'h1000_0007;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0;
	logic [INSTR_W-1:0] ins = '0;
	logic [DATA_W-1:0] a = '0, b = '0, res, sdata, pdata;
	logic [SA_W-1:0] sa = '0;
	logic [REG_IDX_W-1:0] rd;
	logic rv, sreq, exc;
	logic [ADDR_W-1:0] saddr, paddr, ea;
	logic [7:0] pcnt;
	int err_count = 0, checks_done = 0;
	row_t rows [15];
	wide_simd_sub_xor_shift_store wide_simd_sub_xor_shift_store_i (
		.REF_CLK_I(clk), .RESET_I(rst), .ISSUE_VALID_I(vld), .INSTR_I(ins),
		.SRC_FIRST_I(a), .SRC_SECOND_I(b), .SHIFT_AMOUNT_REG_I(sa),
		.RESULT_O(res), .DEST_REG_O(rd), .RESULT_VALID_O(rv),
		.STORE_REQ_O(sreq), .STORE_ADDR_O(saddr), .STORE_DATA_O(sdata),
		.RSVD_INSTR_EXC_O(exc));
	store_sink store_sink_i (.clk_i(clk), .rst_i(rst), .req_i(sreq),
		.addr_i(saddr), .data_i(sdata), .addr_o(paddr), .data_o(pdata),
		.count_o(pcnt));
	function automatic logic [31:0] mm(logic [5:0] fn, logic [4:0] sub);
		return {OPC_MULTIMEDIA, 10'h000, 5'h05, sub, fn};
	endfunction : mm
	function automatic logic [DATA_W-1:0] want(row_t r);
		logic [2*DATA_W-1:0] cat;
		logic [DATA_W-1:0] w;
		cat = {r.a, r.b} >> r.sa;
		w = (r.kind == 3) ? cat[DATA_W-1:0] : r.a ^ r.b;
		for (int g = 0; g < LANES; g++) begin
			if (r.kind < 2)
				w[g*32+:32] = r.a[g*32+:32] - r.b[g*32+:32];
			if (r.kind == 0 && r.a[g*32+:32] < r.b[g*32+:32])
				w[g*32+:32] = SAT_FLOOR;
		end
		return w;
	endfunction : want
	task automatic drive(row_t r);
		@(negedge clk);
		vld = 1'b1;
		ins = r.ins;
		a = r.a;
		b = r.b;
		sa = r.sa;
	endtask : drive
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#5000;
		err_count++;
		wrap_up();
	end
	initial begin
		rows[0] = '{mm(FN_SUBCLASS_1, SUB_SAT_WORD), A, B, 7'h00, 0};
		rows[1] = '{mm(FN_SUBCLASS_0, SUB_WRAP_WORD), A, B, 7'h00, 1};
		rows[2] = '{mm(FN_SUBCLASS_2, SUB_WIDE_XOR), A, C, 7'h00, 2};
		rows[3] = '{mm(FN_SUBCLASS_1, SUB_FUNNEL_RIGHT), A, C, 7'h00, 3};
		rows[4] = '{mm(FN_SUBCLASS_1, SUB_FUNNEL_RIGHT), A, C, 7'h08, 3};
		rows[5] = '{mm(FN_SUBCLASS_1, SUB_FUNNEL_RIGHT), A, C, 7'h10, 3};
		rows[6] = '{mm(FN_SUBCLASS_1, SUB_FUNNEL_RIGHT), A, C, 7'h78, 3};
		rows[7] = '{{OPC_STORE_QUADWORD, 10'h000, 16'hFFF0}, BASE, C, 7'h00, 4};
		rows[8] = '{{6'h30, 26'h0}, A, B, 7'h00, 5};
		rows[9] = '{mm(FN_SUBCLASS_1, 5'h00), A, B, 7'h00, 5};
		rows[10] = '{mm(FN_SUBCLASS_1, SUB_WIDE_XOR), A, B, 7'h00, 5};
		rows[11] = '{mm(FN_SUBCLASS_0, 5'h0C), A, B, 7'h00, 5};
		rows[12] = '{mm(FN_SUBCLASS_2, 5'h01), A, B, 7'h00, 5};
		rows[13] = '{mm(FN_SUBCLASS_0, 5'h00), A, B, 7'h00, 6};
		rows[14] = '{mm(FN_SUBCLASS_1, 5'h1C), A, B, 7'h00, 5};
		repeat (3) @(negedge clk);
		`CHK("rst res", 128'h0, res)
		rst = 1'b0;
		for (int i = 0; i < 15; i++) begin
			drive(rows[i]);
			@(negedge clk);
			vld = 1'b0;
			ea = BASE[31:0] + {{16{rows[i].ins[15]}}, rows[i].ins[15:0]};
			`CHK("valid", 1'(rows[i].kind < 4), rv)
			`CHK("store", 1'(rows[i].kind == 4), sreq)
			`CHK("exc", 1'(rows[i].kind == 5), exc)
			if (rows[i].kind < 4) begin
				`CHK("res", want(rows[i]), res)
				`CHK("rd", 5'h05, rd)
			end
			if (rows[i].kind == 4) begin
				`CHK("addr", ea & 32'hFFFF_FFF0, saddr)
				`CHK("data", C, sdata)
			end
		end
		`CHK("stores", 8'h01, pcnt)
		`CHK("sink data", C, pdata)
		`CHK("sink addr", 32'h0FFF_FFF0, paddr)
		// back to back: result then reserved, result must hold
		drive(rows[0]);
		drive(rows[8]);
		`CHK("b2b valid", 1'b1, rv)
		@(negedge clk);
		vld = 1'b0;
		`CHK("b2b exc", 1'b1, exc)
		`CHK("b2b hold", want(rows[0]), res)
		`CHK("b2b idle", 1'b0, rv)
		// reset in mid-run clears all outputs at once
		drive(rows[7]);
		@(negedge clk);
		vld = 1'b0;
		`CHK("mid req", 1'b1, sreq)
		rst = 1'b1;
		#1;
		`CHK("mid rst", 1'b0, sreq | rv | exc)
		`CHK("mid addr", 32'h0, saddr)
		@(negedge clk);
		rst = 1'b0;
		// first issue after release must work normally
		drive(rows[1]);
		@(negedge clk);
		vld = 1'b0;
		`CHK("post valid", 1'b1, rv)
		`CHK("post res", want(rows[1]), res)
		`CHK("post idle", 1'b0, sreq | exc)
		wrap_up();
	end
endmodule : wide_simd_sub_xor_shift_store_bench
`default_nettype wire
